// ---- verilog/mrs_sequencer.sv ----
// Primary converter round-robin sequencer, result registers and
// per-cell and bar single-pole filters behind an APB slave.
// Assumes conv_data holds the finished conversion of the current slot
// by the slot's last clock; all inputs synchronous to pclk.
//
// Functional notes
// R01: 24 slots, 8 us each, 192 us cycle
// R02: Die, bias ref, 16 cells, bar, aux, spares
// R03: 16-bit results split high/low byte
// R04: Enabling converter resets results to 0x8000
// R05: Result updated right after its slot
// R06: High read freezes low byte until read
// R07: Six to sixteen active cells supported
// R08: Inactive cell slots skipped, timing kept
// R09: Top cell setting, all below active
// R10: Inactive cell results stay 0x8000
// R11: Results raw or filtered per enable
// R12: One 3-bit cutoff for all cells
// R13: Coefficients one half down to 1/128
// R14: Host runs continuous mode for filtering
// R15: Filter starts from its first sample
// R16: Bar filter has own cutoff, enable
// R17: Host allows filter settling time
// R18: Bias reference off at reset, bit-controlled
// R19: Host waits 1.35 ms after bias enable
// R20: Level shifters off in sleep
// R21: Primary and aux converters enabled independently
// R22: Go samples mode, filters, delay, cells
// R23: Run select stop, eight cycles, continuous
// R24: Filter step is shifted difference
// R25: Aux input advances every cycle
`timescale 1ns/1ps
`default_nettype none
module mrs_sequencer #(
   parameter int SLOT_CYCLES = mrs_pkg::SLOT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] conv_data,
   input wire logic sleep_mode,
   output logic [4:0] mux_slot,
   output logic [2:0] aux_sel,
   output logic conv_start,
   output logic level_shift_en,
   output logic thermistor_bias_enable,
   output logic aux_conv_enable
);
   if (SLOT_CYCLES < 2 || SLOT_CYCLES > 2048) begin : g_chk
      $error("SLOT_CYCLES out of range");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} mrs_state_t;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [1:0] primary_run_select;
   logic cell_filter_enable, bar_filter_enable, aux_en, bias_en;
   logic [2:0] cell_filter_cutoff_sel, bar_filter_cutoff_sel;
   logic [5:0] start_dly;
   logic [3:0] highest_active_cell_sel;
   // Settings captured by go
   logic [1:0] s_mode;
   logic s_cell_f, s_bar_f;
   logic [2:0] s_ccut, s_bcut;
   logic [3:0] s_top;

   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire [11:0] roff = paddr - mrs_pkg::OFS_RES;
   wire [4:0] rch = roff[7:3];
   wire res_hit = paddr >= mrs_pkg::OFS_RES && paddr < mrs_pkg::OFS_RES_END;
   wire ctl_hit = paddr == mrs_pkg::OFS_CTRL || paddr == mrs_pkg::OFS_CONF ||
                  paddr == mrs_pkg::OFS_CELLS || paddr == mrs_pkg::OFS_DEV2 ||
                  paddr == mrs_pkg::OFS_STAT;
   wire hit = paddr[1:0] == 2'h0 && (res_hit || ctl_hit);
   // Hold starts at the setup edge, where prdata samples the high byte,
   // so a refresh landing between setup and access cannot tear the pair
   wire setup = psel & ~penable;
   wire rd_hi = setup && !pwrite && hit && res_hit && !roff[2]; // R06
   wire rd_lo = rd && hit && res_hit && roff[2];
   wire go = wr && paddr == mrs_pkg::OFS_CTRL && pwdata[mrs_pkg::F_GO];
   wire go_en = go && pwdata[1:0] != mrs_pkg::RUN_STOP;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_run_select <= mrs_pkg::RUN_STOP;
         cell_filter_enable <= 1'b0;
         bar_filter_enable <= 1'b0;
         aux_en <= 1'b0;
         bias_en <= 1'b0; // R18
         cell_filter_cutoff_sel <= 3'h0;
         bar_filter_cutoff_sel <= 3'h0;
         start_dly <= 6'h00;
         highest_active_cell_sel <= mrs_pkg::TOP_CELL_RST;
      end else if (wr) begin
         if (paddr == mrs_pkg::OFS_CTRL) begin
            primary_run_select <= pwdata[mrs_pkg::F_RUN +: 2];
            cell_filter_enable <= pwdata[mrs_pkg::F_CELL_EN];
            bar_filter_enable <= pwdata[mrs_pkg::F_BAR_EN];
            aux_en <= pwdata[mrs_pkg::F_AUX_EN]; // R21
         end
         if (paddr == mrs_pkg::OFS_CONF) begin
            cell_filter_cutoff_sel <= pwdata[mrs_pkg::F_CCUT +: 3]; // R12
            bar_filter_cutoff_sel <= pwdata[mrs_pkg::F_BCUT +: 3]; // R16
            start_dly <= pwdata[mrs_pkg::F_DLY +: 6];
         end
         if (paddr == mrs_pkg::OFS_CELLS) begin
            highest_active_cell_sel <= pwdata[3:0];
         end
         if (paddr == mrs_pkg::OFS_DEV2) begin
            bias_en <= pwdata[0]; // R18
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   mrs_state_t state;
   logic [10:0] tcnt;
   logic [4:0] slot;
   logic [2:0] rr_cnt, aux_idx;
   logic [5:0] dcnt;
   logic drdy;

   wire ticking = state != ST_IDLE && !sleep_mode; // frozen while asleep
   wire slot_end = ticking && tcnt == 11'(SLOT_CYCLES - 1);
   wire rr_wrap = state == ST_RUN && slot_end && slot == mrs_pkg::SL_LAST;
   wire burst_done = rr_wrap && s_mode == mrs_pkg::RUN_RR8 &&
                     rr_cnt == mrs_pkg::BURST_LAST;
   // Fewer than six cells is not a valid stack; clamp up.
   wire [3:0] top_eff = s_top < mrs_pkg::TOP_CELL_MIN ? mrs_pkg::TOP_CELL_MIN : s_top; // R07
   wire [4:0] cell_no = slot - mrs_pkg::SL_CELL0;
   wire is_cell = slot >= mrs_pkg::SL_CELL0 && slot < mrs_pkg::SL_BAR;
   wire cell_act = is_cell && cell_no[3:0] <= top_eff; // R09
   wire meas = cell_act || (!is_cell && slot <= mrs_pkg::SL_AUX); // R02 R08
   wire wr_en = state == ST_RUN && slot_end && meas; // R05
   wire [4:0] wch = slot == mrs_pkg::SL_AUX ? mrs_pkg::CH_AUX0 + {2'h0, aux_idx} : slot;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         tcnt <= 11'h000;
         slot <= mrs_pkg::SL_DIE;
         rr_cnt <= 3'h0;
         aux_idx <= 3'h0;
         dcnt <= 6'h00;
         drdy <= 1'b0;
      end else if (go) begin
         state <= go_en ? ST_WAIT : ST_IDLE; // R23
         tcnt <= 11'h000;
         slot <= mrs_pkg::SL_DIE;
         rr_cnt <= 3'h0;
         aux_idx <= 3'h0;
         dcnt <= pwdata[mrs_pkg::F_DLY +: 6] == 6'h00 ? start_dly : pwdata[mrs_pkg::F_DLY +: 6];
         drdy <= 1'b0;
      end else if (ticking) begin
         tcnt <= slot_end ? 11'h000 : tcnt + 11'h001; // R01
         if (state == ST_WAIT && slot_end) begin
            if (dcnt == 6'h00) state <= ST_RUN;
            else dcnt <= dcnt - 6'h01;
         end
         if (state == ST_RUN && slot_end) begin
            slot <= slot == mrs_pkg::SL_LAST ? mrs_pkg::SL_DIE : slot + 5'h01; // R08
         end
         if (rr_wrap) begin
            aux_idx <= aux_idx + 3'h1; // R25
            rr_cnt <= rr_cnt + 3'h1;
            if (rr_cnt == mrs_pkg::BURST_LAST) drdy <= 1'b1;
         end
         if (burst_done) state <= ST_IDLE; // R23
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_mode <= mrs_pkg::RUN_STOP;
         s_cell_f <= 1'b0;
         s_bar_f <= 1'b0;
         s_ccut <= 3'h0;
         s_bcut <= 3'h0;
         s_top <= mrs_pkg::TOP_CELL_RST;
      end else if (go) begin
         s_mode <= pwdata[mrs_pkg::F_RUN +: 2]; // R22
         s_cell_f <= pwdata[mrs_pkg::F_CELL_EN];
         s_bar_f <= pwdata[mrs_pkg::F_BAR_EN];
         s_ccut <= cell_filter_cutoff_sel;
         s_bcut <= bar_filter_cutoff_sel;
         s_top <= highest_active_cell_sel;
      end
   end

   // ----------------------------------------
   // Filters
   // ----------------------------------------
   logic [23:0] fst [mrs_pkg::NUM_FILT];
   logic [16:0] finit;
   wire [4:0] fi = slot - mrs_pkg::SL_CELL0;
   wire is_filt = (is_cell && s_cell_f) || (slot == mrs_pkg::SL_BAR && s_bar_f); // R11 R16
   wire [2:0] cut = slot == mrs_pkg::SL_BAR ? s_bcut : s_ccut;
   // Shift 1..7 gives 0.5 down to 1/128; code 7 reuses the slowest.
   wire [2:0] sh = cut == mrs_pkg::CUT_MAX_SHIFT ? mrs_pkg::CUT_MAX_SHIFT : cut + 3'h1; // R13
   wire [23:0] fold = fst[fi];
   wire [23:0] samp = {conv_data, 8'h00};
   wire signed [24:0] diff = $signed({samp[23], samp}) - $signed({fold[23], fold});
   wire signed [24:0] step = diff >>> sh;
   wire [23:0] fnew = finit[fi] ? fold + step[23:0] : samp; // R15 R24
   wire [15:0] wval = is_filt ? fnew[23:mrs_pkg::FRAC] : conv_data; // R03 R11

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < mrs_pkg::NUM_FILT; i++) fst[i] <= 24'h000000;
         finit <= 17'h00000;
      end else if (go) begin
         finit <= 17'h00000; // R15
      end else if (wr_en && is_filt) begin
         fst[fi] <= fnew; // R24
         finit[fi] <= 1'b1;
      end
   end

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   logic [15:0] res [mrs_pkg::NUM_CH];
   logic [7:0] lo_sh [mrs_pkg::NUM_CH];
   logic [26:0] lo_hold;
   // A write racing the high read must not tear the pair; a write racing
   // the low read refreshes the byte that has just been released.
   wire held = (lo_hold[wch] && !(rd_lo && rch == wch)) || (rd_hi && rch == wch); // R06
   wire [7:0] lo_w = lo_sh[wch];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < mrs_pkg::NUM_CH; i++) begin
            res[i] <= mrs_pkg::RESULT_RST;
            lo_sh[i] <= mrs_pkg::RESULT_LO_RST;
         end
      end else if (go_en) begin
         for (int i = 0; i < mrs_pkg::NUM_CH; i++) begin
            res[i] <= mrs_pkg::RESULT_RST; // R04 R10
            lo_sh[i] <= mrs_pkg::RESULT_LO_RST;
         end
      end else begin
         if (wr_en) begin
            res[wch] <= wval; // R05
            if (!held) lo_sh[wch] <= wval[7:0]; // R06
         end
         // Released low byte catches up with its high byte at once
         if (rd_lo && !(wr_en && wch == rch)) lo_sh[rch] <= res[rch][7:0]; // R06
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lo_hold <= 27'h0000000;
      else if (go_en) lo_hold <= 27'h0000000;
      else if (rd_hi) lo_hold[rch] <= 1'b1; // R06
      else if (rd_lo) lo_hold[rch] <= 1'b0;
   end

   // ----------------------------------------
   // APB answer and pins
   // ----------------------------------------
   wire [31:0] stat = {25'h0, state != ST_IDLE, drdy, slot};
   wire [31:0] ctrl = {26'h0, aux_en, 1'b0, bar_filter_enable, cell_filter_enable,
                       primary_run_select};
   wire [31:0] conf = {18'h0, start_dly, 2'h0, bar_filter_cutoff_sel,
                       cell_filter_cutoff_sel};
   wire [31:0] rdata =
      res_hit ? {24'h0, roff[2] ? lo_sh[rch] : res[rch][15:8]} :
      paddr == mrs_pkg::OFS_CTRL ? ctrl :
      paddr == mrs_pkg::OFS_CONF ? conf :
      paddr == mrs_pkg::OFS_CELLS ? {28'h0, highest_active_cell_sel} :
      paddr == mrs_pkg::OFS_DEV2 ? {31'h0, bias_en} :
      paddr == mrs_pkg::OFS_STAT ? stat : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         prdata <= (psel && !penable && hit && !pwrite) ? rdata : 32'h0;
         pslverr <= psel && !penable && !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_slot <= mrs_pkg::SL_DIE;
         aux_sel <= 3'h0;
         conv_start <= 1'b0;
         level_shift_en <= 1'b0;
         thermistor_bias_enable <= 1'b0;
         aux_conv_enable <= 1'b0;
      end else begin
         mux_slot <= slot;
         aux_sel <= aux_idx;
         conv_start <= state == ST_RUN && ticking && tcnt == 11'h000 && meas; // R08
         level_shift_en <= !sleep_mode; // R20
         thermistor_bias_enable <= bias_en; // R18
         aux_conv_enable <= aux_en; // R21
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_last_slot;
      state == ST_RUN && slot_end && slot == mrs_pkg::SL_LAST;
   endsequence
   sequence s_burst_end;
      s_last_slot ##0 (s_mode == mrs_pkg::RUN_RR8 && rr_cnt == mrs_pkg::BURST_LAST && !go);
   endsequence

   go_resets_a: assert property (go_en |=> // R04
      res[0] == mrs_pkg::RESULT_RST && lo_hold == 27'h0)
      else $error("results not reset on go");
   inactive_hold_a: assert property (ticking && is_cell && !cell_act |-> // R10
      res[slot] == mrs_pkg::RESULT_RST)
      else $error("inactive cell result changed");
   slot_len_a: assert property (state == ST_RUN && slot_end && !go |=> tcnt == 11'h000) // R01
      else $error("slot length wrong");
   burst_stop_a: assert property (s_burst_end |=> state == ST_IDLE) // R23
      else $error("burst did not stop");
   low_hold_a: assert property (wr_en && held && !go |=> lo_sh[$past(wch)] == $past(lo_w)) // R06
      else $error("held low byte changed");
   bias_pin_a: assert property (wr && paddr == mrs_pkg::OFS_DEV2 |=> ##1 // R18
      thermistor_bias_enable == $past(pwdata[0], 2))
      else $error("bias enable not applied");
   shifter_off_a: assert property (sleep_mode |=> !level_shift_en) // R20
      else $error("level shifters on in sleep");
   aux_step_a: assert property (s_last_slot ##0 !go |=> aux_idx == $past(aux_idx) + 3'h1) // R25
      else $error("aux input did not advance");
   filter_seed_a: assert property (wr_en && is_filt && !finit[fi] && !go |=> // R15
      fst[$past(fi)] == {$past(conv_data), 8'h00})
      else $error("filter not seeded");
   start_active_a: assert property (conv_start |-> $past(meas)) // R08
      else $error("conversion in skipped slot");
   // Pair release, run control, level shifters and raw results
   lo_release_a: assert property (rd_lo |=> lo_sh[$past(rch)] == res[$past(rch)][7:0]) // R06
      else $error("released low byte stale");
   go_wait_a: assert property (go_en |=> state == ST_WAIT) // R23
      else $error("go did not start a run");
   stop_cmd_a: assert property (go && !go_en |=> state == ST_IDLE) // R23
      else $error("stop command ignored");
   burst_flag_a: assert property (s_burst_end |=> drdy) // R23
      else $error("burst end not flagged");
   level_wake_a: assert property (!sleep_mode |=> level_shift_en) // R20
      else $error("level shifters off while awake");
   // Timing is kept whether or not the slot is measured
   slot_advance_a: assert property (state == ST_RUN && slot_end && slot != mrs_pkg::SL_LAST && // R08
      !go |=> slot == $past(slot) + 5'h01)
      else $error("slot did not advance");
   filter_off_a: assert property (wr_en && !is_filt && !go |=> // R11
      res[$past(wch)] == $past(conv_data))
      else $error("raw result not stored");
endmodule : mrs_sequencer
`default_nettype wire

// ---- verilog/mrs_pkg.sv ----
// Constants for the primary converter round-robin sequencer.
// Assumes a single 200 MHz clock and a 32-bit APB register port.
package mrs_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int SLOT_NS = 8000;
   localparam int RR_NS = 192000;
   localparam int SLOT_CYC = SLOT_NS * CLK_MHZ / 1000;
   localparam int NUM_SLOTS = RR_NS / SLOT_NS;
   localparam logic [2:0] BURST_LAST = 3'h7;
   // ----------------------------------------
   // Slots and result channels
   // ----------------------------------------
   localparam logic [4:0] SL_DIE = 5'h00;
   localparam logic [4:0] SL_REF = 5'h01;
   localparam logic [4:0] SL_CELL0 = 5'h02;
   localparam logic [4:0] SL_BAR = 5'h12;
   localparam logic [4:0] SL_AUX = 5'h13;
   localparam logic [4:0] SL_LAST = 5'h17;
   localparam int NUM_CH = 27;
   localparam int NUM_FILT = 17;
   localparam logic [4:0] CH_AUX0 = 5'h13;
   localparam logic [15:0] RESULT_RST = 16'h8000;
   localparam logic [7:0] RESULT_LO_RST = 8'h00;
   localparam int FRAC = 8;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_CONF = 12'h004;
   localparam logic [11:0] OFS_CELLS = 12'h008;
   localparam logic [11:0] OFS_DEV2 = 12'h00c;
   localparam logic [11:0] OFS_STAT = 12'h010;
   localparam logic [11:0] OFS_RES = 12'h100;
   localparam logic [11:0] OFS_RES_END = 12'h1d8;
   localparam int F_RUN = 0;
   localparam int F_CELL_EN = 2;
   localparam int F_BAR_EN = 3;
   localparam int F_GO = 4;
   localparam int F_AUX_EN = 5;
   localparam int F_CCUT = 0;
   localparam int F_BCUT = 3;
   localparam int F_DLY = 8;
   localparam int F_DRDY = 5;
   localparam int F_BUSY = 6;
   localparam logic [1:0] RUN_STOP = 2'h0;
   localparam logic [1:0] RUN_RR8 = 2'h1;
   localparam logic [1:0] RUN_CONT = 2'h2;
   localparam logic [3:0] TOP_CELL_RST = 4'hf;
   localparam logic [3:0] TOP_CELL_MIN = 4'h5;
   localparam logic [2:0] CUT_MAX_SHIFT = 3'h7;
endpackage : mrs_pkg

// ---- verif/mrs_conv_model.sv ----
// Behavioural stand-in for the analog inputs feeding the primary converter.
// Assumes the sequencer's slot and aux index outputs select what is converted.
`timescale 1ns/1ps
`default_nettype none
module mrs_conv_model (
   input wire logic [4:0] mux_slot,
   input wire logic [2:0] aux_sel,
   input wire logic [15:0] base,
   output logic [15:0] conv_data
);
   // Slot code in the high byte, aux index only on the aux slot, so a
   // result landing in the wrong channel never matches by chance
   assign conv_data = base + {(mux_slot == mrs_pkg::SL_AUX) ? aux_sel : 3'h0, mux_slot, 8'h00};
endmodule : mrs_conv_model
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the primary converter sequencer.
// Assumes the converter model above and a short slot length parameter.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int SC = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] conv_data, base, e, old, nb;
   logic [4:0] mux_slot, hold_slot;
   logic [2:0] aux_sel;
   logic conv_start, level_shift_en, thermistor_bias_enable, aux_conv_enable;
   int mismatches, total_checks, seed, n, top;
   int sels[2] = '{15, 3};

   mrs_sequencer #(.SLOT_CYCLES(SC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_data(conv_data), .sleep_mode(sleep_mode),
      .mux_slot(mux_slot), .aux_sel(aux_sel), .conv_start(conv_start),
      .level_shift_en(level_shift_en), .thermistor_bias_enable(thermistor_bias_enable),
      .aux_conv_enable(aux_conv_enable));
   mrs_conv_model conv_u (.mux_slot(mux_slot), .aux_sel(aux_sel), .base(base),
      .conv_data(conv_data));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ----------------------------------------
   // Tasks and reference model
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk

   // Request held until pready is sampled high; data taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic res(input int ch, input logic [15:0] x);
      apb(1'b0, 12'h100 + 12'(8 * ch), 32'h0);
      chk(rd, {24'h0, x[15:8]});
      apb(1'b0, 12'h104 + 12'(8 * ch), 32'h0);
      chk(rd, {24'h0, x[7:0]});
   endtask : res

   task automatic to_slot(input logic [4:0] s);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (mux_slot !== s && k < 400);
      chk(32'(mux_slot), 32'(s));
   endtask : to_slot

   function automatic logic [15:0] exp_ch(input int ch, input int tp);
      if (ch >= 2 && ch <= 17 && ch - 2 > tp) return 16'h8000;
      if (ch >= 19) return base + {3'(ch - 19), 5'h13, 8'h00};
      return base + {3'h0, 5'(ch), 8'h00};
   endfunction : exp_ch

   // Single pole seeded with the old level, then stepped to the new one
   function automatic logic [15:0] filt(input logic signed [15:0] a,
         input logic signed [15:0] b, input int sh, input int steps);
      int s;
      s = int'(a) * 256;
      for (int i = 0; i < steps; i++) s = s + ((int'(b) * 256 - s) >>> sh);
      return 16'(s >>> 8);
   endfunction : filt

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h99bd;
      mismatches = 0;
      total_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sleep_mode = 1'b0;
      base = 16'h0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'(thermistor_bias_enable), 32'h0);
      apb(1'b0, mrs_pkg::OFS_CELLS, 32'h0);
      chk(rd, 32'hf);
      apb(1'b0, mrs_pkg::OFS_DEV2, 32'h0);
      chk(rd, 32'h0);
      res(0, mrs_pkg::RESULT_RST);
      res(26, mrs_pkg::RESULT_RST);
      apb(1'b0, 12'h020, 32'h0);
      chk({rd[30:0], last_err}, 32'h1);
      apb(1'b0, 12'h102, 32'h0);
      chk(32'(last_err), 32'h1);
      // Burst runs: full stack, then a clamped small stack after it
      foreach (sels[i]) begin
         base <= 16'($random(seed));
         top = (sels[i] < 5) ? 5 : sels[i];
         apb(1'b1, mrs_pkg::OFS_CELLS, 32'(sels[i]));
         apb(1'b1, mrs_pkg::OFS_CONF, 32'h0);
         apb(1'b1, mrs_pkg::OFS_CTRL, 32'h31);
         n = 0;
         do begin
            repeat (50) @(posedge pclk);
            apb(1'b0, mrs_pkg::OFS_STAT, 32'h0);
            n++;
         end while (rd[mrs_pkg::F_DRDY] !== 1'b1 && n < 60);
         chk(32'(rd[6:5]), 32'h1);
         for (int c = 0; c < 27; c++) res(c, exp_ch(c, top));
      end
      chk(32'(aux_conv_enable), 32'h1);
      // Continuous run: low byte freeze, sleep, slot timing
      apb(1'b1, mrs_pkg::OFS_CTRL, 32'h32);
      repeat (300) @(posedge pclk);
      apb(1'b1, mrs_pkg::OFS_CELLS, 32'hf);
      e = exp_ch(0, 5);
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, {24'h0, e[15:8]});
      base <= base ^ 16'h5aa5;
      repeat (400) @(posedge pclk);
      apb(1'b0, 12'h104, 32'h0);
      chk(rd, {24'h0, e[7:0]});
      res(0, exp_ch(0, 5));
      res(17, mrs_pkg::RESULT_RST);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      hold_slot = mux_slot;
      chk(32'(level_shift_en), 32'h0);
      repeat (40) @(posedge pclk);
      chk(32'(mux_slot), 32'(hold_slot));
      sleep_mode <= 1'b0;
      to_slot(mrs_pkg::SL_REF);
      to_slot(mrs_pkg::SL_DIE);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(mux_slot === mrs_pkg::SL_DIE && n > SC) && n < 1000);
      chk(32'(n), 32'(mrs_pkg::NUM_SLOTS * SC));
      // Filters: every cutoff code, bar cutoff running the other way
      for (int k = 0; k < 8; k++) begin
         base <= 16'($random(seed));
         apb(1'b1, mrs_pkg::OFS_CONF, {26'h0, 3'(6 - k), 3'(k)});
         apb(1'b1, mrs_pkg::OFS_CTRL, 32'h3e);
         repeat (300) @(posedge pclk);
         to_slot(mrs_pkg::SL_AUX);
         old = base;
         nb = 16'($random(seed));
         base <= nb;
         repeat (2) begin
            to_slot(mrs_pkg::SL_REF);
            to_slot(mrs_pkg::SL_AUX);
         end
         apb(1'b1, mrs_pkg::OFS_CTRL, 32'h30);
         // Code 7 is the spare code and shares the slowest shift
         res(2, filt(old + 16'h0200, nb + 16'h0200, (k == 7) ? 7 : k + 1, 2));
         res(18, filt(old + 16'h1200, nb + 16'h1200, (k == 7) ? 7 : 7 - k, 2));
      end
      apb(1'b1, mrs_pkg::OFS_DEV2, 32'h1);
      repeat (3) @(posedge pclk);
      chk(32'(thermistor_bias_enable), 32'h1);
      // Bias settling forbids further commands, so the run stops here
      wrap_up();
   end

   initial begin
      #150000;
      mismatches++;
      wrap_up();
   end
endmodule : tb
`default_nettype wire
